// File: move_exec_defs.svh
`ifndef MOVE_EXEC_DEFS_SVH
`define MOVE_EXEC_DEFS_SVH

// APB register byte offsets.
`define APB_ADDR_W 8
`define REG_INSTR 8'h00
`define REG_WORK 8'h04
`define REG_STATUS 8'h08
`define REG_BANK 8'h0C
`define REG_PAGE_LATCH 8'h10
`define REG_OPTION 8'h14
`define REG_PTR0 8'h18
`define REG_PTR1 8'h1C
`define REG_PC 8'h20
`define REG_MEM_ADDR 8'h24
`define REG_MEM_DATA 8'h28
`define REG_ERROR 8'h2C

// Widths of the core registers.
`define DATA_W 8
`define BANK_W 5
`define PCL_W 7
`define FILE_W 7
`define PTR_W 16
`define PTR_NUM 2
`define PC_W 15
`define STATUS_W 3
`define INSTR_W 16
`define REL_W 6
`define ERROR_W 1

// Instruction word fields.
`define F_OPC_HI 15
`define F_OPC_LO 12
`define F_MODE_SEL 2
`define F_MODE_HI 1
`define F_MODE_LO 0
`define F_REL_SEL 6
`define OPC_W 4

// Instruction class codes.
`define OPC_NOP 4'h0
`define OPC_LD_BANK 4'h1
`define OPC_LD_PAGE 4'h2
`define OPC_LD_WORK 4'h3
`define OPC_ST_FILE 4'h4
`define OPC_ST_IND 4'h5
`define OPC_ST_REL 4'h6
`define OPC_LD_OPTION 4'h7

// Pointer update modes.
`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_INC 2'h2
`define MODE_POST_DEC 2'h3

// File addresses that act as indirect windows.
`define WIN0_ADDR 7'h00
`define WIN1_ADDR 7'h01

// Option reset value and bit position of the illegal-opcode error flag.
`define OPTION_RESET 8'hFF
`define ERR_ILLEGAL 0

`endif

// File: move_exec_pkg.sv
`default_nettype none
package move_exec_pkg;
`include "move_exec_defs.svh"

typedef enum logic [`OPC_W-1:0] {
    OP_NOP = `OPC_NOP,
    OP_LD_BANK = `OPC_LD_BANK,
    OP_LD_PAGE = `OPC_LD_PAGE,
    OP_LD_WORK = `OPC_LD_WORK,
    OP_ST_FILE = `OPC_ST_FILE,
    OP_ST_IND = `OPC_ST_IND,
    OP_ST_REL = `OPC_ST_REL,
    OP_LD_OPTION = `OPC_LD_OPTION
} op_class_t;

typedef enum logic [1:0] {
    MODE_PRE_INC = `MODE_PRE_INC,
    MODE_PRE_DEC = `MODE_PRE_DEC,
    MODE_POST_INC = `MODE_POST_INC,
    MODE_POST_DEC = `MODE_POST_DEC
} ptr_mode_t;

endpackage
`default_nettype wire

// File: literal_and_indirect_move_exec.sv
// How it works
// - The bank literal load puts its 5-bit operand in the bank select register, flags untouched.
// - The page latch literal load puts its 7-bit operand in the program counter high latch.
// - The work literal load puts its 8-bit operand in the accumulator in one cycle.
// - The store to file copies the accumulator to the file addressed by its 7-bit operand.
// - The indirect store writes through a pointer updated pre/post by one as the mode field says.
// - The relative indirect store targets pointer plus a signed six-bit offset, pointer unchanged.
// - A store to an indirect window address goes to the location the matching pointer holds.
// - Each pointer is 16 bits wide and wraps around on increment or decrement.
// - Pointer updates never change any status flag.
// - The option load copies the accumulator into the option configuration register.
`timescale 1ns/10ps
`default_nettype none
`include "move_exec_defs.svh"

module literal_and_indirect_move_exec
    import move_exec_pkg::*;
#(
    parameter int DATA_DEPTH = 128
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [`DATA_W-1:0] work_reg,
    output logic [`BANK_W-1:0] bank_select_reg,
    output logic [`PCL_W-1:0] program_counter_high_latch,
    output logic [`DATA_W-1:0] option_config
);

    localparam int IDX_W = $clog2(DATA_DEPTH);
    localparam logic [`APB_ADDR_W-1:0] PTR_ADDR [`PTR_NUM] = '{`REG_PTR0, `REG_PTR1};

    logic [`DATA_W-1:0] work_q;
    logic [`BANK_W-1:0] bank_q;
    logic [`PCL_W-1:0] pcl_q;
    logic [`DATA_W-1:0] option_q;
    logic [`PTR_W-1:0] ptr_q [`PTR_NUM];
    logic [`PC_W-1:0] pc_q;
    logic [`STATUS_W-1:0] status_q;
    logic [`INSTR_W-1:0] instr_q;
    logic [IDX_W-1:0] mem_addr_q;
    logic [`ERROR_W-1:0] error_q;
    logic [31:0] prdata_q;
    logic [`DATA_W-1:0] mem_q [DATA_DEPTH];

    logic setup_phase;
    logic access_phase;
    logic apb_write;
    logic addr_mapped;
    logic exec;
    logic [`INSTR_W-1:0] instr;
    op_class_t opc;
    ptr_mode_t mode;
    logic ptr_sel;
    logic [`PTR_W-1:0] ptr_cur;
    logic [`PTR_W-1:0] ptr_inc;
    logic [`PTR_W-1:0] ptr_dec;
    logic [`PTR_W-1:0] ptr_rel;
    logic [`PTR_W-1:0] lin_addr;
    logic [`FILE_W-1:0] file_addr;
    logic [`PTR_W-1:0] eff_addr;
    logic ld_bank;
    logic ld_page;
    logic ld_work;
    logic ld_option;
    logic st_mem;
    logic ptr_upd;
    logic [`PTR_W-1:0] ptr_new;
    logic illegal;
    logic mem_we;
    logic [IDX_W-1:0] mem_widx;
    logic [`DATA_W-1:0] mem_wdata;
    logic [31:0] rd_data;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign apb_write = access_phase & pwrite;
    // Every access completes without wait states.
    assign pready = 1'b1;
    assign pslverr = access_phase & ~addr_mapped;

    assign addr_mapped = paddr inside {`REG_INSTR, `REG_WORK, `REG_STATUS, `REG_BANK,
        `REG_PAGE_LATCH, `REG_OPTION, `REG_PTR0, `REG_PTR1,
        `REG_PC, `REG_MEM_ADDR, `REG_MEM_DATA, `REG_ERROR};

    // Writing the instruction register issues the instruction at that same edge.
    assign exec = apb_write & (paddr == `REG_INSTR);
    assign instr = pwdata[`INSTR_W-1:0];
    assign opc = op_class_t'(instr[`F_OPC_HI:`F_OPC_LO]);
    assign mode = ptr_mode_t'(instr[`F_MODE_HI:`F_MODE_LO]);
    assign file_addr = instr[`FILE_W-1:0];

    // Pointer arithmetic is plain 16-bit, so it wraps at both ends.
    assign ptr_inc = ptr_cur + 1'b1;
    assign ptr_dec = ptr_cur - 1'b1;
    assign ptr_rel = ptr_cur + {{(`PTR_W-`REL_W){instr[`REL_W-1]}}, instr[`REL_W-1:0]};
    assign lin_addr = {{(`PTR_W-`BANK_W-`FILE_W){1'b0}}, bank_q, file_addr};

    assign ptr_sel = (opc == OP_ST_REL) ? instr[`F_REL_SEL]
        : (opc == OP_ST_FILE) ? (file_addr == `WIN1_ADDR)
        : instr[`F_MODE_SEL];
    assign ptr_cur = ptr_q[ptr_sel];

    always_comb
    begin
        ld_bank = 1'b0;
        ld_page = 1'b0;
        ld_work = 1'b0;
        ld_option = 1'b0;
        st_mem = 1'b0;
        ptr_upd = 1'b0;
        ptr_new = ptr_cur;
        eff_addr = ptr_cur;
        illegal = 1'b0;
        unique case (opc)
            OP_NOP: illegal = 1'b0;
            OP_LD_BANK: ld_bank = 1'b1;
            OP_LD_PAGE: ld_page = 1'b1;
            OP_LD_WORK: ld_work = 1'b1;
            OP_ST_FILE:
            begin
                st_mem = 1'b1;
                eff_addr = ((file_addr == `WIN0_ADDR) || (file_addr == `WIN1_ADDR))
                    ? ptr_cur : lin_addr;
            end
            OP_ST_IND:
            begin
                st_mem = 1'b1;
                ptr_upd = 1'b1;
                unique case (mode)
                    MODE_PRE_INC:
                    begin
                        ptr_new = ptr_inc;
                        eff_addr = ptr_inc;
                    end
                    MODE_PRE_DEC:
                    begin
                        ptr_new = ptr_dec;
                        eff_addr = ptr_dec;
                    end
                    MODE_POST_INC:
                    begin
                        ptr_new = ptr_inc;
                        eff_addr = ptr_cur;
                    end
                    MODE_POST_DEC:
                    begin
                        ptr_new = ptr_dec;
                        eff_addr = ptr_cur;
                    end
                endcase
            end
            OP_ST_REL:
            begin
                st_mem = 1'b1;
                eff_addr = ptr_rel;
            end
            OP_LD_OPTION: ld_option = 1'b1;
            default: illegal = 1'b1;
        endcase
    end

    // Instruction stores take priority; software memory writes cannot coincide with them.
    assign mem_we = (exec & st_mem) | (apb_write & (paddr == `REG_MEM_DATA));
    assign mem_widx = (exec & st_mem) ? eff_addr[IDX_W-1:0] : mem_addr_q;
    assign mem_wdata = (exec & st_mem) ? work_q : pwdata[`DATA_W-1:0];

    for (genvar i = 0; i < DATA_DEPTH; i++)
    begin : g_mem
        always_ff @(posedge clock or negedge reset_n)
        begin
            if (!reset_n)
            begin
                mem_q[i] <= '0;
            end
            else if (mem_we && (mem_widx == IDX_W'(i)))
            begin
                mem_q[i] <= mem_wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            work_q <= '0;
        end
        else if (exec & ld_work)
        begin
            work_q <= instr[`DATA_W-1:0];
        end
        else if (apb_write && (paddr == `REG_WORK))
        begin
            work_q <= pwdata[`DATA_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bank_q <= '0;
        end
        else if (exec & ld_bank)
        begin
            bank_q <= instr[`BANK_W-1:0];
        end
        else if (apb_write && (paddr == `REG_BANK))
        begin
            bank_q <= pwdata[`BANK_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pcl_q <= '0;
        end
        else if (exec & ld_page)
        begin
            pcl_q <= instr[`PCL_W-1:0];
        end
        else if (apb_write && (paddr == `REG_PAGE_LATCH))
        begin
            pcl_q <= pwdata[`PCL_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            option_q <= `OPTION_RESET;
        end
        else if (exec & ld_option)
        begin
            option_q <= work_q;
        end
        else if (apb_write && (paddr == `REG_OPTION))
        begin
            option_q <= pwdata[`DATA_W-1:0];
        end
    end

    for (genvar p = 0; p < `PTR_NUM; p++)
    begin : g_ptr
        always_ff @(posedge clock or negedge reset_n)
        begin
            if (!reset_n)
            begin
                ptr_q[p] <= '0;
            end
            else if (exec & ptr_upd & (ptr_sel == 1'(p)))
            begin
                ptr_q[p] <= ptr_new;
            end
            else if (apb_write && (paddr == PTR_ADDR[p]))
            begin
                ptr_q[p] <= pwdata[`PTR_W-1:0];
            end
        end
    end

    // Status is written only by software; no instruction of this group touches it.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_q <= '0;
        end
        else if (apb_write && (paddr == `REG_STATUS))
        begin
            status_q <= pwdata[`STATUS_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pc_q <= '0;
            instr_q <= '0;
        end
        else if (exec)
        begin
            pc_q <= pc_q + 1'b1;
            instr_q <= instr;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mem_addr_q <= '0;
        end
        else if (apb_write && (paddr == `REG_MEM_ADDR))
        begin
            mem_addr_q <= pwdata[IDX_W-1:0];
        end
    end

    // Sticky illegal-opcode flag; a new event wins over a write-one clear.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            error_q <= '0;
        end
        else if ((exec & illegal) | (apb_write && (paddr == `REG_ERROR) && pwdata[`ERR_ILLEGAL]))
        begin
            error_q[`ERR_ILLEGAL] <= exec & illegal;
        end
    end

    always_comb
    begin
        rd_data = '0;
        unique case (paddr)
            `REG_INSTR: rd_data[`INSTR_W-1:0] = instr_q;
            `REG_WORK: rd_data[`DATA_W-1:0] = work_q;
            `REG_STATUS: rd_data[`STATUS_W-1:0] = status_q;
            `REG_BANK: rd_data[`BANK_W-1:0] = bank_q;
            `REG_PAGE_LATCH: rd_data[`PCL_W-1:0] = pcl_q;
            `REG_OPTION: rd_data[`DATA_W-1:0] = option_q;
            `REG_PTR0: rd_data[`PTR_W-1:0] = ptr_q[0];
            `REG_PTR1: rd_data[`PTR_W-1:0] = ptr_q[1];
            `REG_PC: rd_data[`PC_W-1:0] = pc_q;
            `REG_MEM_ADDR: rd_data[IDX_W-1:0] = mem_addr_q;
            `REG_MEM_DATA: rd_data[`DATA_W-1:0] = mem_q[mem_addr_q];
            `REG_ERROR: rd_data[`ERROR_W-1:0] = error_q;
            default: rd_data = '0;
        endcase
    end

    // Read data is captured at the end of the setup cycle and held through the access.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_q <= '0;
        end
        else if (setup_phase)
        begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
        end
    end

    assign prdata = prdata_q;
    assign work_reg = work_q;
    assign bank_select_reg = bank_q;
    assign program_counter_high_latch = pcl_q;
    assign option_config = option_q;

endmodule
`default_nettype wire

// File: literal_and_indirect_move_exec_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "move_exec_defs.svh"
module literal_and_indirect_move_exec_monitor
    import move_exec_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`DATA_W-1:0] work_reg,
    input wire logic [`BANK_W-1:0] bank_select_reg,
    input wire logic [`PCL_W-1:0] program_counter_high_latch,
    input wire logic [`DATA_W-1:0] option_config
);
    logic iss;
    logic acc;
    logic [3:0] op;
    assign acc = psel && penable;
    assign iss = acc && pwrite && paddr == `REG_INSTR;
    assign op = pwdata[15:12];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_bank_load: assert property (
        iss && op == `OPC_LD_BANK |=> bank_select_reg == $past(pwdata[4:0]))
        else $error("bank select load wrong");
    chk_page_load: assert property (
        iss && op == `OPC_LD_PAGE |=> program_counter_high_latch == $past(pwdata[6:0]))
        else $error("page latch load wrong");
    chk_work_load: assert property (
        iss && op == `OPC_LD_WORK |=> work_reg == $past(pwdata[7:0]))
        else $error("work load wrong");
    chk_option_copy: assert property (
        iss && op == `OPC_LD_OPTION |=> option_config == $past(work_reg))
        else $error("option copy wrong");
    chk_store_keeps_regs: assert property (
        iss && op inside {`OPC_ST_FILE, `OPC_ST_IND, `OPC_ST_REL}
        |=> $stable(work_reg) && $stable(option_config) && $stable(bank_select_reg))
        else $error("store altered a core register");
    chk_nop_quiet: assert property (
        iss && op == `OPC_NOP |=> $stable(work_reg) && $stable(bank_select_reg)
        && $stable(program_counter_high_latch) && $stable(option_config))
        else $error("no-operation altered a register");
    chk_idle_hold: assert property (
        !(acc && pwrite) [*2] |-> $stable(work_reg) && $stable(option_config))
        else $error("register changed without a write");
    chk_zero_wait: assert property (psel |-> pready)
        else $error("ready low during transfer");
    chk_unmapped_err: assert property (acc && paddr > `REG_ERROR |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    cov_indirect: cover property (iss && op == `OPC_ST_IND);
    cov_relative: cover property (iss && op == `OPC_ST_REL);
    cov_refused: cover property (acc && pslverr);
endmodule
bind literal_and_indirect_move_exec literal_and_indirect_move_exec_monitor mon (
    .clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .work_reg, .bank_select_reg, .program_counter_high_latch, .option_config
);
`default_nettype wire

// File: tb_literal_and_indirect_move_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "move_exec_defs.svh"
module tb_literal_and_indirect_move_exec
    import move_exec_pkg::*;
;
    logic clock = 0;
    logic reset_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [`APB_ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata, pc;
    logic pready, pslverr, serr;
    logic [7:0] work_reg, option_config, fa;
    logic [4:0] bank_select_reg;
    logic [6:0] program_counter_high_latch;
    logic [15:0] p, d, tgt;
    logic [5:0] k;
    logic [1:0] m;
    int err_count = 0;
    int cmp_count = 0;
    literal_and_indirect_move_exec uut (
        .clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .work_reg, .bank_select_reg, .program_counter_high_latch, .option_config
    );
    initial
    begin
        forever #20 clock = ~clock;
    end
    task stop_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task apb(input logic [7:0] a, input logic [31:0] wd, input logic w);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task ins(input logic [15:0] w);
        apb(`REG_INSTR, {16'h0, w}, 1'b1);
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(a, 32'h0, 1'b0);
        check(nm, rdata, e);
    endtask
    task mchk(input logic [15:0] t, input logic [7:0] e);
        apb(`REG_MEM_ADDR, {25'h0, t[6:0]}, 1'b1);
        rchk("memory", `REG_MEM_DATA, {24'h0, e});
    endtask
    initial
    begin
        #100000;
        err_count++;
        stop_test;
    end
    initial
    begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        rchk("option reset", `REG_OPTION, 32'hFF);
        apb(`REG_STATUS, 32'h7, 1'b1);
        ins(16'h101F);
        check("bank", 32'(bank_select_reg), 32'h1F);
        ins(16'h207F);
        check("page latch", 32'(program_counter_high_latch), 32'h7F);
        ins(16'h30A5);
        check("work", 32'(work_reg), 32'hA5);
        ins(16'h7000);
        check("option", 32'(option_config), 32'hA5);
        ins(16'h4045);
        mchk(16'h0045, 8'hA5);
        // Increments start at the top and decrements at zero so every mode wraps.
        for (int i = 0; i < 4; i++)
        begin
            m = i[1:0];
            p = m[0] ? 16'h0000 : 16'hFFFF;
            d = m[0] ? 16'hFFFF : 16'h0001;
            fa = m[0] ? `REG_PTR1 : `REG_PTR0;
            tgt = m[1] ? p : p + d;
            ins({8'h30, 6'h04, m});
            apb(fa, {16'h0, p}, 1'b1);
            ins({4'h5, 9'h0, m[0], m});
            mchk(tgt, {6'h04, m});
            rchk("pointer", fa, {16'h0, p + d});
        end
        apb(`REG_PTR1, 32'h10, 1'b1);
        for (int j = 0; j < 2; j++)
        begin
            k = j ? 6'h1F : 6'h20;
            tgt = 16'h0010 + {{10{k[5]}}, k};
            ins({8'h30, 2'h1, k});
            ins({4'h6, 5'h0, 1'b1, k});
            mchk(tgt, {2'h1, k});
            rchk("relative pointer", `REG_PTR1, 32'h10);
        end
        ins(16'h3077);
        ins(16'h4001);
        mchk(16'h0010, 8'h77);
        mchk(16'h0001, 8'h00);
        rchk("window pointer", `REG_PTR1, 32'h10);
        apb(`REG_PC, 32'h0, 1'b0);
        pc = rdata;
        ins(16'h0000);
        rchk("pc", `REG_PC, {17'h0, 15'(pc + 1)});
        check("nop work", 32'(work_reg), 32'h77);
        check("nop bank", 32'(bank_select_reg), 32'h1F);
        check("nop latch", 32'(program_counter_high_latch), 32'h7F);
        check("nop option", 32'(option_config), 32'hA5);
        // An undefined class leaves the accumulator alone and raises the sticky error flag, which write-one clears.
        ins(16'h8000);
        check("illegal work", 32'(work_reg), 32'h77);
        rchk("error flag", `REG_ERROR, 32'h1);
        apb(`REG_ERROR, 32'h1, 1'b1);
        rchk("error clear", `REG_ERROR, 32'h0);
        apb(8'h30, 32'h0, 1'b0);
        check("unmapped data", rdata, 32'h0);
        check("unmapped error", 32'(serr), 32'h1);
        rchk("status", `REG_STATUS, 32'h7);
        stop_test;
    end
endmodule
`default_nettype wire
